//--- src/fbn_pkg.sv
package fbn_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_SYS = 8'h00;
  localparam logic [7:0] ADDR_UNIT = 8'h04;
  localparam logic [7:0] ADDR_FAULT_SEL = 8'h08;
  localparam logic [7:0] ADDR_IDLE_SEL = 8'h0C;
  localparam logic [7:0] ADDR_CNT_EN = 8'h10;
  localparam logic [7:0] ADDR_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_CNT_CLR = 8'h18;
  localparam logic [7:0] ADDR_CNT_SEL = 8'h1C;
  localparam logic [7:0] ADDR_CNT_VAL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_MASK = 8'h28;
  localparam logic [7:0] ADDR_PORTS = 8'h2C;
  localparam logic [7:0] ADDR_VALVE = 8'h30;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SYS_SRC_SW = 0;
  localparam int SYS_MSB_FIRST = 1;
  localparam int UNIT_CTL_MON = 0;
  localparam int UNIT_OUT_MON = 1;
  localparam int UNIT_SC_EN = 2;
  localparam int UNIT_SC_MANUAL = 3;
  localparam int ST_CTL_UV = 0;
  localparam int ST_OUT_UV = 1;
  localparam int ST_SC = 2;
  localparam int ST_CNT = 3;
  // ----------------------------------------
  // Reset values, limit scale and limit maximum
  // ----------------------------------------
  localparam logic [1:0] SYS_RESET = 2'h0;
  localparam logic [3:0] UNIT_RESET = 4'h5;
  localparam logic [15:0] LIMIT_RESET = 16'h0001;
  localparam logic [31:0] LIMIT_SCALE = 32'h0000_03E8;
  localparam logic [15:0] LIMIT_MAX = 16'hFDE8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_HZ = 20000000;
  localparam longint SAVE_PERIOD_S = 3600;
  localparam longint SAVE_CYCLES = CLK_HZ * SAVE_PERIOD_S;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    FB_OFF = 2'b00,
    FB_HOLD = 2'b01,
    FB_ON = 2'b10
  } fbn_fb_t;
  typedef enum logic [2:0] {
    LM_AUTO = 3'b000,
    LM_10_HDX = 3'b001,
    LM_10_FDX = 3'b010,
    LM_100_HDX = 3'b011,
    LM_100_FDX = 3'b100
  } fbn_link_t;
endpackage

//--- src/fbn_node.sv
// Notes on behaviour
// - Switch source: front switch, off/hold, all
// - Software source: per-channel off/hold/on
// - One byte-order bit, low first default
// - Control supply undervoltage error, enabled default
// - Output supply undervoltage error, disabled default
// - Short-circuit error when detection enabled
// - Auto restart clears; manual persists
// - Comm fault: per-channel off/hold/on
// - Idle: separate per-channel off/hold/on
// - Per-channel settings only under software source
// - Count switchings; error above limit
// - Limit scaled by one thousand
// - Save counts hourly, resume after power
// - Clear command zeroes addressed counter
// - Per-port link mode, auto default
`timescale 1ns/1ps
module fbn_node
  import fbn_pkg::*;
#(
  parameter int NCH = 8,
  parameter longint SAVE_CYC = SAVE_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Network state from the protocol engine
  input wire logic comm_fault,
  input wire logic net_idle,
  // Pins
  input wire logic fb_switch_hold,
  input wire logic ctl_uv_pin,
  input wire logic out_uv_pin,
  input wire logic [NCH-1:0] valve_short_pin,
  // Persistent store
  input wire logic [NCH*32-1:0] nv_count,
  output logic nv_save,
  output logic [NCH*32-1:0] nv_data,
  // Outputs
  output logic [NCH-1:0] valve_out,
  output logic msb_first,
  output logic [2:0] first_network_port,
  output logic [2:0] second_network_port,
  output logic irq
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (NCH < 1 || NCH > 16) begin : g_bad
    $error("NCH must be 1 to 16");
  end
  if (SAVE_CYC < 1) begin : g_bad2
    $error("SAVE_CYC must be positive");
  end
  if (SAVE_CYC > 64'(40'hFF_FFFF_FFFF)) begin : g_bad3
    $error("SAVE_CYC must fit the 40-bit save timer");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sys;
    logic [3:0] unit;
    logic [2*NCH-1:0] fsel;
    logic [2*NCH-1:0] isel;
    logic [NCH-1:0] cen;
    logic [15:0] limit;
    logic [4:0] csel;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [2:0] p1;
    logic [2:0] p2;
    logic [NCH-1:0] vcmd;
    logic [NCH-1:0] vout;
    logic [NCH-1:0] vprev;
    logic [NCH*32-1:0] cnt;
    logic [NCH-1:0] sc_lat;
    logic [39:0] tmr;
    logic save;
    logic loaded;
    logic aph;
    logic awr;
    logic [7:0] aad;
    logic [31:0] rdata;
    logic irq;
    logic rdy;
    logic resp;
    logic [2*NCH+2:0] s1;
    logic [2*NCH+2:0] s2;
  } fbn_st_t;

  fbn_st_t q, d;
  logic [31:0] wd;
  logic [NCH-1:0] sc_now;
  logic over;
  logic ctl_uv, out_uv, sw_hold;
  logic [1:0] mode;
  logic [31:0] cv;

  assign hrdata = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp = q.resp;
  assign nv_save = q.save;
  assign nv_data = q.cnt;
  assign valve_out = q.vout;
  assign msb_first = q.sys[SYS_MSB_FIRST];
  assign first_network_port = q.p1;
  assign second_network_port = q.p2;
  assign irq = q.irq;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    wd = hwdata;
    over = 1'b0;
    mode = 2'b00;
    cv = 32'h0000_0000;
    d.save = 1'b0;
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    d.s1 = {fb_switch_hold, ctl_uv_pin, out_uv_pin, valve_short_pin, {NCH{1'b0}}};
    d.s2 = q.s1;
    sw_hold = q.s2[2*NCH+2];
    ctl_uv = q.s2[2*NCH+1];
    out_uv = q.s2[2*NCH];
    sc_now = q.s2[2*NCH-1:NCH];
    // ----------------------------------------
    // Resume from persistent store once after each reset
    // ----------------------------------------
    if (!q.loaded) begin
      d.cnt = nv_count;
      d.loaded = 1'b1;
    end
    // ----------------------------------------
    // Hourly save
    // ----------------------------------------
    if (q.tmr >= 40'(SAVE_CYC - 1)) begin
      d.tmr = 40'h00_0000_0000;
      d.save = 1'b1;
    end else begin
      d.tmr = q.tmr + 40'h00_0000_0001;
    end
    // ----------------------------------------
    // Fallback selection per channel
    // ----------------------------------------
    for (int i = 0; i < NCH; i++) begin
      if (q.sys[SYS_SRC_SW]) begin
        mode = sw_hold ? FB_HOLD : FB_OFF;
      end else if (comm_fault) begin
        mode = q.fsel[2*i +: 2];
      end else begin
        mode = q.isel[2*i +: 2];
      end
      if (comm_fault || net_idle) begin
        unique case (mode)
          FB_OFF: begin
            d.vout[i] = 1'b0;
          end
          FB_ON: begin
            d.vout[i] = 1'b1;
          end
          default: begin
            d.vout[i] = q.vout[i];
          end
        endcase
      end else begin
        d.vout[i] = q.vcmd[i];
      end
      // Switching counter
      d.vprev[i] = q.vout[i];
      cv = d.cnt[32*i +: 32];
      if (q.loaded && q.vout[i] != q.vprev[i] && cv != 32'hFFFF_FFFF) begin
        cv = cv + 32'h0000_0001;
      end
      if (q.cen[i] && cv > 32'(q.limit) * LIMIT_SCALE) begin
        over = 1'b1;
      end
      d.cnt[32*i +: 32] = cv;
      // Short-circuit latch
      if (q.unit[UNIT_SC_MANUAL]) begin
        d.sc_lat[i] = q.sc_lat[i] | sc_now[i];
      end else begin
        d.sc_lat[i] = sc_now[i];
      end
    end
    // ----------------------------------------
    // Register write, data phase
    // ----------------------------------------
    if (q.aph && q.awr) begin
      unique case (q.aad)
        ADDR_SYS: begin
          d.sys = wd[1:0];
        end
        ADDR_UNIT: begin
          d.unit = wd[3:0];
        end
        ADDR_FAULT_SEL: begin
          d.fsel = wd[2*NCH-1:0];
        end
        ADDR_IDLE_SEL: begin
          d.isel = wd[2*NCH-1:0];
        end
        ADDR_CNT_EN: begin
          d.cen = wd[NCH-1:0];
        end
        ADDR_LIMIT: begin
          if (wd[15:0] != 16'h0000 && wd[15:0] <= LIMIT_MAX) begin
            d.limit = wd[15:0];
          end
        end
        ADDR_CNT_CLR: begin
          if (wd[4:0] < 5'(NCH)) begin
            d.cnt[32*wd[4:0] +: 32] = 32'h0000_0000;
          end
        end
        ADDR_CNT_SEL: begin
          d.csel = wd[4:0];
        end
        ADDR_MASK: begin
          d.mask = wd[3:0];
        end
        ADDR_PORTS: begin
          d.p1 = wd[2:0] > 3'h4 ? LM_AUTO : wd[2:0];
          d.p2 = wd[6:4] > 3'h4 ? LM_AUTO : wd[6:4];
        end
        ADDR_VALVE: begin
          d.vcmd = wd[NCH-1:0];
        end
        default: begin
          d.limit = q.limit;
        end
      endcase
    end
    // ----------------------------------------
    // Status: write one to clear, set wins
    // ----------------------------------------
    if (q.aph && q.awr && q.aad == ADDR_STATUS) begin
      d.stat = q.stat & ~wd[3:0];
    end
    if (q.unit[UNIT_CTL_MON] && ctl_uv) begin
      d.stat[ST_CTL_UV] = 1'b1;
    end
    if (q.unit[UNIT_OUT_MON] && out_uv) begin
      d.stat[ST_OUT_UV] = 1'b1;
    end
    if (q.unit[UNIT_SC_EN] && |q.sc_lat) begin
      d.stat[ST_SC] = 1'b1;
    end else if (q.unit[UNIT_SC_EN] && !q.unit[UNIT_SC_MANUAL]) begin
      d.stat[ST_SC] = 1'b0;
    end
    if (!q.unit[UNIT_SC_EN]) begin
      d.stat[ST_SC] = 1'b0;
    end
    if (over) begin
      d.stat[ST_CNT] = 1'b1;
    end
    d.irq = |(d.stat & q.mask);
    // ----------------------------------------
    // Bus response and address phase capture
    // ----------------------------------------
    d.rdy = 1'b1;
    d.resp = 1'b0;
    d.aph = hsel && hready && htrans[1];
    d.awr = hwrite;
    d.aad = haddr;
    // ----------------------------------------
    // Read data, after this cycle's write
    // ----------------------------------------
    d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        ADDR_SYS: begin
          d.rdata = 32'(d.sys);
        end
        ADDR_UNIT: begin
          d.rdata = 32'(d.unit);
        end
        ADDR_FAULT_SEL: begin
          d.rdata = 32'(d.fsel);
        end
        ADDR_IDLE_SEL: begin
          d.rdata = 32'(d.isel);
        end
        ADDR_CNT_EN: begin
          d.rdata = 32'(d.cen);
        end
        ADDR_LIMIT: begin
          d.rdata = 32'(d.limit);
        end
        ADDR_CNT_SEL: begin
          d.rdata = 32'(d.csel);
        end
        ADDR_CNT_VAL: begin
          if (d.csel < 5'(NCH)) begin
            d.rdata = d.cnt[32*d.csel +: 32];
          end
        end
        ADDR_STATUS: begin
          d.rdata = 32'(d.stat);
        end
        ADDR_MASK: begin
          d.rdata = 32'(d.mask);
        end
        ADDR_PORTS: begin
          d.rdata = {25'h000_0000, d.p2, 1'b0, d.p1};
        end
        ADDR_VALVE: begin
          d.rdata = 32'(d.vout);
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.sys <= SYS_RESET;
      q.unit <= UNIT_RESET;
      q.limit <= LIMIT_RESET;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

//--- tb/fbn_sva.sv
`timescale 1ns/1ps
module fbn_sva #(
  parameter int NCH = 8
) (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Outputs
  input wire logic nv_save,
  input wire logic [NCH-1:0] valve_out,
  input wire logic msb_first,
  input wire logic [2:0] first_network_port,
  input wire logic [2:0] second_network_port
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_ready_a: assert property (hsel && htrans[1] |-> hreadyout)
    else $error("bus stalled");
  bus_okay_a: assert property (hsel && htrans[1] |=> !hresp)
    else $error("bus error response");
  rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  save_pulse_a: assert property (nv_save |=> !nv_save [*8])
    else $error("save pulse too long");
  port_one_a: assert property (first_network_port <= 3'h4)
    else $error("first port mode out of range");
  port_two_a: assert property (second_network_port <= 3'h4)
    else $error("second port mode out of range");
  order_reset_a: assert property ($rose(hresetn) |-> !msb_first)
    else $error("byte order not low first");
  valve_reset_a: assert property ($rose(hresetn) |-> valve_out == '0)
    else $error("valves on after reset");
endmodule
bind fbn_node fbn_sva #(.NCH(NCH)) u_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .nv_save, .valve_out, .msb_first, .first_network_port,
  .second_network_port);

//--- tb/fbn_plc.sv
`timescale 1ns/1ps
module fbn_plc (
  // Clock and command
  input wire logic hclk,
  input wire logic [1:0] state,
  // Network state
  output logic comm_fault,
  output logic net_idle
);
  initial comm_fault = 1'h0;
  initial net_idle = 1'h0;
  always @(posedge hclk) begin
    comm_fault <= state[0];
    net_idle <= state[1];
  end
endmodule

//--- tb/fbn_node_tb_top.sv
`timescale 1ns/1ps
module fbn_node_tb_top;
  import fbn_pkg::*;
  // ----
  // Signals
  // ----
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, sw = 1'h0;
  logic cuv = 1'h0, ouv = 1'h0;
  logic [1:0] htrans = 2'h0, st = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] haddr = 8'h00, shp = 8'h00;
  logic [31:0] hwdata = 32'h0, r, v, s;
  logic [255:0] nvc = 256'h0;
  wire [31:0] hrdata;
  wire hrdy, hresp, irq, nvs, msb, cf, ni;
  wire [7:0] vo;
  wire [2:0] p1, p2;
  wire [255:0] nvd;
  int fails = 0, comparisons = 0, seed = 3413, cyc = 0, i;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  always #25 hclk = ~hclk;
  fbn_node #(.NCH(8), .SAVE_CYC(100)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .comm_fault(cf),
    .net_idle(ni), .fb_switch_hold(sw), .ctl_uv_pin(cuv), .out_uv_pin(ouv),
    .valve_short_pin(shp), .nv_count(nvc), .nv_save(nvs), .nv_data(nvd), .valve_out(vo),
    .msb_first(msb), .first_network_port(p1), .second_network_port(p2), .irq(irq));
  fbn_plc plc (.hclk(hclk), .state(st), .comm_fault(cf), .net_idle(ni));
  // ----
  // Tasks
  // ----
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'h1);
    r = hrdata;
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'h0, a, 32'h0);
    `CHK(r, e)
  endtask
  task automatic put(input logic [12:0] x);
    @(posedge hclk);
    {st, sw, cuv, ouv, shp} <= x;
    repeat (6) @(posedge hclk);
    #1;
  endtask
  function automatic logic [7:0] ex(input logic [15:0] m);
    for (int k = 0; k < 8; k++) ex[k] = i[1] ? (i[0] & v[k]) : (m[2*k+1] | (m[2*k] & v[k]));
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      wrap_up;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    v = $random(seed);
    nvc[31:0] <= {24'h0, v[7:0]};
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    rc(ADDR_CNT_VAL, {24'h0, v[7:0]});
    rc(ADDR_SYS, 32'h0);
    rc(ADDR_UNIT, 32'h5);
    rc(ADDR_LIMIT, 32'h1);
    rc(8'h40, 32'h0);
    xf(1'h1, ADDR_SYS, 32'h2);
    `CHK(msb, 1'h1)
    for (i = 0; i < 8; i++) begin
      xf(1'h1, ADDR_PORTS, {25'h0, 3'(7 - i), 1'h0, 3'(i)});
      `CHK(p1, (i > 4) ? 3'h0 : 3'(i))
      `CHK(p2, (i < 3) ? 3'h0 : 3'(7 - i))
    end
    $display("done reset and modes");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      s = $random(seed);
      s = s & ~((s & 32'hAAAAAAAA) >> 1);
      xf(1'h1, ADDR_SYS, {31'h0, i[1]});
      xf(1'h1, ADDR_FAULT_SEL, s);
      xf(1'h1, ADDR_IDLE_SEL, {s[15:0], s[31:16]});
      xf(1'h1, ADDR_VALVE, v);
      put({2'h0, i[0], 10'h0});
      put({2'h1, i[0], 10'h0});
      `CHK(vo, ex(s[15:0]))
      put({2'h0, i[0], 10'h0});
      put({2'h2, i[0], 10'h0});
      `CHK(vo, ex(s[31:16]))
      put(13'h0);
    end
    $display("done fallback");
    xf(1'h1, ADDR_MASK, 32'hF);
    put({5'h2, 8'h04});
    rc(ADDR_STATUS, 32'h5);
    `CHK(irq, 1'h1)
    put(13'h0);
    xf(1'h1, ADDR_STATUS, 32'hF);
    rc(ADDR_STATUS, 32'h0);
    `CHK(irq, 1'h0)
    xf(1'h1, ADDR_UNIT, 32'hF);
    put({5'h1, 8'h04});
    put(13'h0);
    xf(1'h1, ADDR_STATUS, 32'hF);
    rc(ADDR_STATUS, 32'h4);
    xf(1'h1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    #1;
    `CHK(irq, 1'h0)
    xf(1'h1, ADDR_MASK, 32'hF);
    $display("done errors");
    xf(1'h1, ADDR_VALVE, 32'h0);
    xf(1'h1, ADDR_CNT_CLR, 32'h0);
    rc(ADDR_CNT_VAL, 32'h0);
    xf(1'h1, ADDR_CNT_EN, 32'h1);
    for (i = 1; i <= 1001; i++) begin
      xf(1'h1, ADDR_VALVE, {31'h0, i[0]});
      if (i == 1000) rc(ADDR_STATUS, 32'h4);
    end
    repeat (4) @(posedge hclk);
    rc(ADDR_STATUS, 32'hC);
    rc(ADDR_CNT_VAL, 32'h3E9);
    do @(posedge hclk); while (nvs !== 1'h1);
    `CHK(nvd[31:0], 32'h3E9)
    nvc <= nvd;
    hresetn <= 1'h0;
    @(posedge hclk);
    hresetn <= 1'h1;
    rc(ADDR_CNT_VAL, 32'h3E9);
    rc(ADDR_STATUS, 32'h0);
    $display("done counter");
    wrap_up;
  end
endmodule
